//--- rbmc_board_model.sv
`default_nettype none
// ***********************************************************************
// board side: reset button, strap resistors, pll lock and programmer
// ***********************************************************************
module rbmc_board_model (
  input  wire logic       want_rst_n_i,  // bench asks for reset button
  input  wire logic [1:0] want_mode_i,   // bench strap for clock mode
  input  wire logic       want_strap_i,  // bench strap on crystal pin
  input  wire logic       want_cfg_n_i,  // bench asks for programmer
  input  wire logic       want_lock_i,   // bench pll lock level
  input  wire logic       want_test_i,   // bench test pin level
  input  wire logic       crystal_drive_pin_o_i,      // device drive on crystal pin
  input  wire logic       crystal_drive_pin_oe_n_i,   // device drive enable, low
  output logic            ext_rst_n_o,   // reset pin level
  output logic      [1:0] mode_o,        // clock mode pin levels
  output logic            crystal_drive_pin_pin_o,    // resolved crystal pin level
  output logic            cfg_n_o,       // config pin level
  output logic            test_o,        // factory test pin
  output logic            lock_o         // pll lock level
);
  timeunit 1ns;
  timeprecision 1ps;
  // the strap resistor only wins while the device releases the pin
  assign crystal_drive_pin_pin_o  = crystal_drive_pin_oe_n_i ? want_strap_i : crystal_drive_pin_o_i;
  // programmer holds config until the bench changes it after reset
  assign cfg_n_o     = want_cfg_n_i;
  // test pin held at ground except for one bench corner case
  assign test_o      = want_test_i;
  assign ext_rst_n_o = want_rst_n_i;
  assign mode_o      = want_mode_i;
  assign lock_o      = want_lock_i;
endmodule
`default_nettype wire

//--- rbmc_pkg.sv
`default_nettype none
package rbmc_pkg;
  // ***********************************************************************
  // timing
  // ***********************************************************************
  localparam int unsigned RBMC_RESET_INDICATOR_OUT_N_CYCLES = 512;   // stretch after release
  localparam int unsigned RBMC_CNT_W       = 10;    // counter width less one

  // ***********************************************************************
  // clock source and pll selections
  // ***********************************************************************
  localparam logic [1:0] RBMC_SRC_EXT_OSC = 2'h0;   // external oscillator
  localparam logic [1:0] RBMC_SRC_ONCHIP  = 2'h1;   // on-chip oscillator
  localparam logic [1:0] RBMC_SRC_CRYSTAL = 2'h2;   // crystal
  localparam logic [1:0] RBMC_MODE_00     = 2'h0;   // pll off, strap used
  localparam logic [1:0] RBMC_MODE_01     = 2'h1;   // pll off, crystal
  localparam logic [1:0] RBMC_MODE_10     = 2'h2;   // pll on, strap used
  localparam logic [1:0] RBMC_MODE_11     = 2'h3;   // pll on, crystal

  // ***********************************************************************
  // register bus: status and control words
  // ***********************************************************************
  localparam logic [3:0] RBMC_ADDR_STATUS = 4'h0;   // read-only state
  localparam logic [3:0] RBMC_ADDR_CTRL   = 4'h4;   // software control
  localparam int unsigned RBMC_ST_PLL_EN  = 0;      // status: pll enabled
  localparam int unsigned RBMC_ST_SRC_LO  = 1;      // status: source [2:1]
  localparam int unsigned RBMC_ST_PROG    = 3;      // status: flash prog
  localparam int unsigned RBMC_ST_RESET_INDICATOR_OUT_N    = 4;      // status: reset out low
  localparam int unsigned RBMC_ST_MODE_LO = 5;      // status: mode [6:5]
  localparam int unsigned RBMC_ST_LOCK    = 7;      // status: pll lock
  localparam int unsigned RBMC_CT_SWRST   = 0;      // ctrl: assert reset out
  localparam logic [31:0] RBMC_CTRL_RST   = 32'h0;  // ctrl reset value
  localparam logic [31:0] RBMC_UNMAPPED   = 32'h0;  // unmapped read value

  // ***********************************************************************
  // sequencer states
  // ***********************************************************************
  typedef enum logic [2:0] {
    RBMC_ST_HOLD    = 3'b001,
    RBMC_ST_STRETCH = 3'b010,
    RBMC_ST_RUN     = 3'b100
  } rbmc_state_t;
endpackage
`default_nettype wire

//--- rbmc_reset_boot.sv
`default_nettype none
module rbmc_reset_boot
  import rbmc_pkg::*;
#(
  parameter int unsigned STRETCH = RBMC_RESET_INDICATOR_OUT_N_CYCLES  // reset out length
) (
  input  wire logic        clk_i,                 // system clock
  input  wire logic        rst_i,                 // synchronous reset
  input  wire logic        external_reset_in_n,   // async reset pin, low
  input  wire logic        src_reset_i,           // other reset sources
  input  wire logic        pll_lock_i,            // pll lock, async
  input  wire logic [1:0]  boot_clock_select,     // clock mode pins
  input  wire logic        crystal_drive_pin_i,   // crystal pin input
  output logic             crystal_drive_pin_o,   // crystal pin output
  output logic             crystal_drive_pin_oe_n,// low while driven
  output logic             crystal_input_en_o,    // crystal input in use
  input  wire logic        reset_config_pin_n,    // config pin, low active
  input  wire logic        test_pin_i,            // factory test pin
  output logic             system_clock_out,      // clock output
  output logic             core_reset_o,          // core/peripheral reset
  output logic             reset_indicator_out_n, // reset out, low
  output logic             pll_enable_o,          // pll in normal mode
  output logic      [1:0]  clock_source_o,        // selected source
  output logic             prog_mode_o,           // flash programming
  output logic             serial_flash_port_en_o,// port owns flash
  input  wire logic        cyc_i,                 // wishbone cycle
  input  wire logic        stb_i,                 // wishbone strobe
  input  wire logic        we_i,                  // write enable
  input  wire logic [3:0]  adr_i,                 // byte address
  input  wire logic [3:0]  sel_i,                 // byte lanes
  input  wire logic [31:0] dat_i,                 // write data
  output logic      [31:0] dat_o,                 // read data
  output logic             ack_o                  // acknowledge
);
  // ***********************************************************************
  // pin synchronisation
  // ***********************************************************************
  localparam int unsigned NSYNC = 7;
  logic [NSYNC-1:0] pins_s;
  logic             rst_pin_s, lock_s, crystal_drive_pin_s, reset_config_pin_n_n_s, test_s;
  logic [1:0]       mode_s;

  rbmc_sync2 #(.WIDTH(NSYNC)) u_sync (
    .clk_i (clk_i),
    .d_i   ({external_reset_in_n, pll_lock_i, boot_clock_select,
             crystal_drive_pin_i, reset_config_pin_n, test_pin_i}),
    .q_o   (pins_s)
  );
  assign {rst_pin_s, lock_s, mode_s, crystal_drive_pin_s, reset_config_pin_n_n_s, test_s} = pins_s;

  // ***********************************************************************
  // immediate reset path
  // ***********************************************************************
  // combinational on purpose: the pin must reset without any clock edge
  assign core_reset_o = ~external_reset_in_n | rst_i | src_reset_i;

  // ***********************************************************************
  // strap decode
  // ***********************************************************************
  function automatic logic [2:0] rbmc_decode(input logic [1:0] m,
                                             input logic x);
    logic [1:0] src;
    src = x ? RBMC_SRC_ONCHIP : RBMC_SRC_EXT_OSC;
    unique case (m)
      RBMC_MODE_00: rbmc_decode = {1'b0, src};
      RBMC_MODE_01: rbmc_decode = {1'b0, RBMC_SRC_CRYSTAL};
      RBMC_MODE_10: rbmc_decode = {1'b1, src};
      RBMC_MODE_11: rbmc_decode = {1'b1, RBMC_SRC_CRYSTAL};
    endcase
  endfunction

  // ***********************************************************************
  // sequencer and strap latch
  // ***********************************************************************
  rbmc_state_t          state_r, state_nxt;
  logic [RBMC_CNT_W:0]  cnt_r, cnt_nxt;
  logic [1:0]           mode_r, mode_nxt;
  logic                 crystal_drive_pin_r, crystal_drive_pin_nxt;
  logic                 prog_r, prog_nxt;
  logic                 in_reset;
  logic [31:0]          ctrl_w;
  logic                 swrst;

  assign swrst    = ctrl_w[RBMC_CT_SWRST];
  // synchronised pin plus the raw source and software resets for the stretch logic
  assign in_reset = ~rst_pin_s | src_reset_i | swrst;

  always_comb begin
    state_nxt = state_r;
    cnt_nxt   = cnt_r;
    mode_nxt  = mode_r;
    crystal_drive_pin_nxt  = crystal_drive_pin_r;
    prog_nxt  = prog_r;
    unique case (state_r)
      RBMC_ST_HOLD: begin
        // straps follow the pins while reset stands, frozen on exit
        mode_nxt = mode_s;
        crystal_drive_pin_nxt = crystal_drive_pin_s;
        prog_nxt = ~reset_config_pin_n_n_s & ~test_s;
        cnt_nxt  = '0;
        if (!in_reset && lock_s) begin
          state_nxt = RBMC_ST_STRETCH;
        end
      end
      RBMC_ST_STRETCH: begin
        if (in_reset || !lock_s) begin
          state_nxt = RBMC_ST_HOLD;
        end else if (cnt_r == (RBMC_CNT_W+1)'(STRETCH - 1)) begin
          state_nxt = RBMC_ST_RUN;
        end else begin
          cnt_nxt = cnt_r + 1'b1;
        end
      end
      RBMC_ST_RUN: begin
        if (in_reset || !lock_s) begin
          state_nxt = RBMC_ST_HOLD;
        end
      end
      default: state_nxt = RBMC_ST_HOLD;
    endcase
  end

  // register stage; the strap latch is cleared only by a fresh reset
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_r <= RBMC_ST_HOLD;
      cnt_r   <= '0;
      mode_r  <= RBMC_MODE_00;
      crystal_drive_pin_r  <= 1'b0;
      prog_r  <= 1'b0;
    end else begin
      state_r <= state_nxt;
      cnt_r   <= cnt_nxt;
      mode_r  <= mode_nxt;
      crystal_drive_pin_r  <= crystal_drive_pin_nxt;
      prog_r  <= prog_nxt;
    end
  end

  // ***********************************************************************
  // outputs
  // ***********************************************************************
  logic [2:0] dec;
  logic       strap_mode;
  logic       reset_indicator_out_n_n_r;

  assign dec        = rbmc_decode(mode_r, crystal_drive_pin_r);
  assign strap_mode = ~mode_r[0];      // modes 00 and 10 read the strap

  // registered so the indicator never glitches
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      reset_indicator_out_n_n_r <= 1'b0;
    end else begin
      reset_indicator_out_n_n_r <= (state_nxt == RBMC_ST_RUN);
    end
  end
  assign reset_indicator_out_n = reset_indicator_out_n_n_r;

  assign pll_enable_o   = dec[2];
  assign clock_source_o = dec[1:0];
  // released as an input when the strap is read, else driven low
  assign crystal_drive_pin_oe_n = strap_mode;
  assign crystal_drive_pin_o    = 1'b0;
  assign crystal_input_en_o = (dec[1:0] != RBMC_SRC_ONCHIP);
  // trade-off: forwarding the clock keeps it phase-exact, no divider
  assign system_clock_out = clk_i;
  assign prog_mode_o = prog_r;
  // port gets flash only once the chip has left reset in that mode
  assign serial_flash_port_en_o = prog_r & reset_indicator_out_n_n_r;

  // ***********************************************************************
  // register bus
  // ***********************************************************************
  logic [31:0] status_w;
  always_comb begin
    status_w = 32'h0;
    status_w[RBMC_ST_PLL_EN]               = dec[2];
    status_w[RBMC_ST_SRC_LO +: 2]          = dec[1:0];
    status_w[RBMC_ST_PROG]                 = prog_r;
    status_w[RBMC_ST_RESET_INDICATOR_OUT_N]                 = ~reset_indicator_out_n_n_r;
    status_w[RBMC_ST_MODE_LO +: 2]         = mode_r;
    status_w[RBMC_ST_LOCK]                 = lock_s;
  end

  rbmc_wb_regs u_regs (
    .clk_i    (clk_i),
    .rst_i    (rst_i),
    .cyc_i    (cyc_i),
    .stb_i    (stb_i),
    .we_i     (we_i),
    .adr_i    (adr_i),
    .sel_i    (sel_i),
    .dat_i    (dat_i),
    .dat_o    (dat_o),
    .ack_o    (ack_o),
    .status_i (status_w),
    .ctrl_o   (ctrl_w)
  );

  // ***********************************************************************
  // checks
  // ***********************************************************************
  int unsigned low_cnt;
  always_ff @(posedge clk_i) begin
    if (rst_i || state_r == RBMC_ST_HOLD) begin
      low_cnt <= 0;
    end else if (!reset_indicator_out_n_n_r) begin
      low_cnt <= low_cnt + 1;
    end
  end

  // reset out: exact stretch length, and low through every reset cause
  a_reset_indicator_out_n_release: assert property (
    @(posedge clk_i) disable iff (rst_i)
    $rose(reset_indicator_out_n_n_r) |-> low_cnt == STRETCH)
    else $error("reset out released after wrong count");

  a_reset_indicator_out_n_hold: assert property (
    @(posedge clk_i) disable iff (rst_i)
    in_reset |=> !reset_indicator_out_n_n_r)
    else $error("reset out high during reset");

  a_reset_indicator_out_n_stretch: assert property (
    @(posedge clk_i) disable iff (rst_i)
    state_r == RBMC_ST_STRETCH |-> !reset_indicator_out_n_n_r)
    else $error("reset out high while stretching");

  // core reset must follow the pin and sources with no clock edge
  a_core_reset: assert property (
    @(posedge clk_i)
    !external_reset_in_n |-> core_reset_o)
    else $error("core not in reset with pin low");

  a_core_source: assert property (
    @(posedge clk_i)
    src_reset_i |-> core_reset_o)
    else $error("core not in reset with source high");

  // clock mode decode, one property per strap pattern
  a_mode00_src: assert property (
    @(posedge clk_i) disable iff (rst_i)
    mode_r == RBMC_MODE_00 |-> !pll_enable_o &&
      clock_source_o == (crystal_drive_pin_r ? RBMC_SRC_ONCHIP : RBMC_SRC_EXT_OSC))
    else $error("mode 00 decode wrong");

  a_mode01_src: assert property (
    @(posedge clk_i) disable iff (rst_i)
    mode_r == RBMC_MODE_01 |-> !pll_enable_o &&
      clock_source_o == RBMC_SRC_CRYSTAL)
    else $error("mode 01 decode wrong");

  a_mode10_src: assert property (
    @(posedge clk_i) disable iff (rst_i)
    mode_r == RBMC_MODE_10 |-> pll_enable_o &&
      clock_source_o == (crystal_drive_pin_r ? RBMC_SRC_ONCHIP : RBMC_SRC_EXT_OSC))
    else $error("mode 10 decode wrong");

  a_mode11_src: assert property (
    @(posedge clk_i) disable iff (rst_i)
    mode_r == RBMC_MODE_11 |-> pll_enable_o &&
      clock_source_o == RBMC_SRC_CRYSTAL)
    else $error("mode 11 decode wrong");

  // crystal pins: released for the strap, input unless on-chip source
  a_strap_pin: assert property (
    @(posedge clk_i) disable iff (rst_i)
    !mode_r[0] |-> crystal_drive_pin_oe_n)
    else $error("crystal pin driven in strap mode");

  a_osc_drive: assert property (
    @(posedge clk_i) disable iff (rst_i)
    mode_r[0] |-> !crystal_drive_pin_oe_n)
    else $error("crystal pin released in crystal mode");

  a_crystal_drive_pin_input: assert property (
    @(posedge clk_i) disable iff (rst_i)
    crystal_input_en_o == (mode_r[0] || !crystal_drive_pin_r))
    else $error("crystal input use wrong");

  // programming strap taken on the edge that leaves hold
  a_prog_entry: assert property (
    @(posedge clk_i) disable iff (rst_i)
    state_r == RBMC_ST_HOLD && state_nxt == RBMC_ST_STRETCH
      |=> prog_r == (!$past(reset_config_pin_n_n_s) && !$past(test_s)))
    else $error("programming strap latched wrong");

  a_strap_frozen: assert property (
    @(posedge clk_i) disable iff (rst_i)
    state_r == RBMC_ST_RUN ##1 state_r == RBMC_ST_RUN
      |-> $stable(mode_r) && $stable(crystal_drive_pin_r) && $stable(prog_r))
    else $error("straps changed outside reset");

  a_flash_port: assert property (
    @(posedge clk_i) disable iff (rst_i)
    serial_flash_port_en_o |-> prog_r && reset_indicator_out_n_n_r)
    else $error("flash port on outside programming");

  a_flash_grant: assert property (
    @(posedge clk_i) disable iff (rst_i)
    prog_r && reset_indicator_out_n_n_r |-> serial_flash_port_en_o)
    else $error("flash port off in programming mode");
endmodule
`default_nettype wire

//--- rbmc_sync2.sv
`default_nettype none
module rbmc_sync2
  import rbmc_pkg::*;
#(
  parameter int unsigned WIDTH = 1
) (
  input  wire logic             clk_i,   // system clock
  input  wire logic [WIDTH-1:0] d_i,     // asynchronous pins
  output logic      [WIDTH-1:0] q_o      // synchronised pins
);
  // ***********************************************************************
  // two-flop synchroniser, no reset so the chain cannot glitch on release
  // ***********************************************************************
  logic [WIDTH-1:0] meta_r;
  logic [WIDTH-1:0] q_r;

  // first stage is read only by the second
  always_ff @(posedge clk_i) begin
    meta_r <= d_i;
    q_r    <= meta_r;
  end
  assign q_o = q_r;
endmodule
`default_nettype wire

//--- rbmc_wb_regs.sv
`default_nettype none
module rbmc_wb_regs
  import rbmc_pkg::*;
(
  input  wire logic        clk_i,     // system clock
  input  wire logic        rst_i,     // synchronous reset
  input  wire logic        cyc_i,     // wishbone cycle
  input  wire logic        stb_i,     // wishbone strobe
  input  wire logic        we_i,      // write enable
  input  wire logic [3:0]  adr_i,     // byte address
  input  wire logic [3:0]  sel_i,     // byte lanes
  input  wire logic [31:0] dat_i,     // write data
  output logic      [31:0] dat_o,     // read data (registered)
  output logic             ack_o,     // acknowledge
  input  wire logic [31:0] status_i,  // block state to read
  output logic      [31:0] ctrl_o     // control word
);
  // ***********************************************************************
  // classic wishbone slave, one wait state
  // ***********************************************************************
  logic [31:0] ctrl_r, ctrl_nxt;
  logic [31:0] dat_r, dat_nxt;
  logic        ack_r, ack_nxt;
  logic        req;

  // ack drops the cycle after it is given, so a held strobe is not doubled
  always_comb begin
    req      = cyc_i & stb_i & ~ack_r;
    ack_nxt  = req;
    ctrl_nxt = ctrl_r;
    dat_nxt  = dat_r;
    if (req && we_i && adr_i == RBMC_ADDR_CTRL) begin
      for (int b = 0; b < 4; b++) begin
        if (sel_i[b]) begin
          ctrl_nxt[b*8 +: 8] = dat_i[b*8 +: 8];
        end
      end
    end
    if (req && !we_i) begin
      unique case (adr_i)
        RBMC_ADDR_STATUS: dat_nxt = status_i;
        RBMC_ADDR_CTRL:   dat_nxt = ctrl_r;
        default:          dat_nxt = RBMC_UNMAPPED;
      endcase
    end
  end

  // register stage
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl_r <= RBMC_CTRL_RST;
      dat_r  <= 32'h0;
      ack_r  <= 1'b0;
    end else begin
      ctrl_r <= ctrl_nxt;
      dat_r  <= dat_nxt;
      ack_r  <= ack_nxt;
    end
  end
  assign dat_o  = dat_r;
  assign ack_o  = ack_r;
  assign ctrl_o = ctrl_r;
endmodule
`default_nettype wire

//--- test_reset_boot_mode_control.sv
`default_nettype none
`define CHK(a, b, m) begin checks_done++; if ((a) !== (b)) begin \
  err_count++; $display("CHECK FAILED %0t %s", $time, m); end end
module test_reset_boot_mode_control;
  import rbmc_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int unsigned STR = 8;  // short stretch keeps the run brief
  logic clk_i = 0, rst_i = 1, src_reset_i = 0;
  logic want_rst_n = 1, want_strap = 0, want_cfg_n = 1, want_lock = 1;
  logic want_test = 0;
  logic [1:0] want_mode = 2'h0;
  logic cyc_i = 0, stb_i = 0, we_i = 0;
  logic [3:0] adr_i = 4'h0, sel_i = 4'hf;
  logic [31:0] dat_i = 32'h0, rd;
  logic ext_n, xpin, cfg_n, tst, lock, xo, xoe_n, xin_en, sclk, crst;
  logic reset_indicator_out_n_n, pll_en, prog, sfp_en, ack_o;
  logic [1:0] mode, src;
  logic [31:0] dat_o;
  logic [15:0] lfsr = 16'h4ac6;  // seed 19142
  int err_count = 0, checks_done = 0, n;
  // ***********************************************************************
  // clock, partner and design
  // ***********************************************************************
  always #2 clk_i = ~clk_i;
  rbmc_board_model board (.want_rst_n_i(want_rst_n), .want_mode_i(want_mode),
    .want_strap_i(want_strap), .want_cfg_n_i(want_cfg_n),
    .want_lock_i(want_lock), .want_test_i(want_test),
    .crystal_drive_pin_o_i(xo), .crystal_drive_pin_oe_n_i(xoe_n),
    .ext_rst_n_o(ext_n), .mode_o(mode), .crystal_drive_pin_pin_o(xpin), .cfg_n_o(cfg_n),
    .test_o(tst), .lock_o(lock));
  rbmc_reset_boot #(.STRETCH(STR)) DUT (.clk_i(clk_i), .rst_i(rst_i),
    .external_reset_in_n(ext_n), .src_reset_i(src_reset_i),
    .pll_lock_i(lock), .boot_clock_select(mode), .crystal_drive_pin_i(xpin),
    .crystal_drive_pin_o(xo), .crystal_drive_pin_oe_n(xoe_n),
    .crystal_input_en_o(xin_en), .reset_config_pin_n(cfg_n),
    .test_pin_i(tst), .system_clock_out(sclk), .core_reset_o(crst),
    .reset_indicator_out_n(reset_indicator_out_n_n), .pll_enable_o(pll_en),
    .clock_source_o(src), .prog_mode_o(prog),
    .serial_flash_port_en_o(sfp_en), .cyc_i(cyc_i), .stb_i(stb_i),
    .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i),
    .dat_o(dat_o), .ack_o(ack_o));
  // ***********************************************************************
  // helpers
  // ***********************************************************************
  function automatic logic [15:0] step(input logic [15:0] l);
    return {l[14:0], l[15] ^ l[13] ^ l[12] ^ l[10]};
  endfunction
  // source expected from the latched mode and crystal strap
  function automatic logic [1:0] exp_src(input logic [1:0] m, input logic s);
    if (m[0]) return RBMC_SRC_CRYSTAL;
    return s ? RBMC_SRC_ONCHIP : RBMC_SRC_EXT_OSC;
  endfunction
  task automatic print_verdict();
    if (err_count == 0 && checks_done > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  // classic single cycle; waits for ack with a bound
  task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d);
    @(posedge clk_i);
    cyc_i <= 1; stb_i <= 1; we_i <= w; adr_i <= a; dat_i <= d;
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (ack_o !== 1'b1 && n < 50);
    rd = dat_o;
    cyc_i <= 0; stb_i <= 0; we_i <= 0;
    if (n >= 50) begin err_count++; print_verdict(); end
  endtask
  // counts edges until reset out rises; a hang ends the run
  task automatic wait_reset_indicator_out_n();
    n = 0;
    while (reset_indicator_out_n_n !== 1'b1 && n < 2000) begin
      @(posedge clk_i);
      n++;
    end
    if (n >= 2000) begin err_count++; print_verdict(); end
  endtask
  task automatic check_boot(input logic [1:0] m, input logic s, input logic c);
    @(negedge clk_i);
    `CHK(pll_en, m[1], "pll enable")
    `CHK(src, exp_src(m, s), "clock source")
    `CHK(xoe_n, ~m[0], "crystal pin direction")
    `CHK(xin_en, (exp_src(m, s) != RBMC_SRC_ONCHIP), "crystal in")
    `CHK(prog, ~c, "programming mode")
    `CHK(sfp_en, ~c, "flash port access")
  endtask
  // ***********************************************************************
  // main sequence
  // ***********************************************************************
  logic [1:0] m;
  logic s, c;
  initial begin
    repeat (12) @(posedge clk_i);
    rst_i <= 0;
    @(negedge clk_i);
    `CHK(reset_indicator_out_n_n, 1'b0, "reset out after reset")
    `CHK(sclk, clk_i, "clock out")
    @(posedge clk_i);
    #1;
    `CHK(sclk, 1'b1, "clock out high phase")
    for (int i = 0; i < 8; i++) begin
      m = i[2:1];
      s = i[0];
      lfsr = step(lfsr);
      c = lfsr[0];
      @(posedge clk_i);
      want_rst_n <= 0; want_mode <= m; want_strap <= s; want_cfg_n <= c;
      @(negedge clk_i);
      `CHK(crst, 1'b1, "core reset not immediate")
      repeat (5) @(posedge clk_i);
      want_rst_n <= 1;
      wait_reset_indicator_out_n();
      `CHK((n >= STR && n <= STR + 5), 1'b1, "stretch length")
      check_boot(m, s, c);
      @(posedge clk_i);
      want_mode <= lfsr[2:1]; want_strap <= ~s; want_cfg_n <= ~c;
      repeat (6) @(posedge clk_i);
      check_boot(m, s, c);
      wb(1'b0, RBMC_ADDR_STATUS, 32'h0);
      `CHK(rd[7:0], {1'b1, m, 1'b0, ~c, exp_src(m, s), m[1]}, "status")
    end
    wb(1'b1, RBMC_ADDR_STATUS, 32'hffff_ffff);        // read-only place
    wb(1'b0, RBMC_ADDR_STATUS, 32'h0);
    `CHK(rd[4], 1'b0, "status written")
    wb(1'b0, 4'h8, 32'h0);
    `CHK(rd, RBMC_UNMAPPED, "unmapped read")
    wb(1'b1, RBMC_ADDR_CTRL, 32'h1);
    repeat (3) @(posedge clk_i);
    `CHK(reset_indicator_out_n_n, 1'b0, "software reset out")
    wb(1'b0, RBMC_ADDR_CTRL, 32'h0);
    `CHK(rd[0], 1'b1, "ctrl readback")
    wb(1'b1, RBMC_ADDR_CTRL, 32'h0);
    wait_reset_indicator_out_n();
    `CHK((n >= STR && n <= STR + 5), 1'b1, "stretch after ctrl")
    @(posedge clk_i);
    src_reset_i <= 1;
    @(negedge clk_i);
    `CHK(crst, 1'b1, "source reset to core")
    @(posedge clk_i);
    src_reset_i <= 0;
    @(negedge clk_i);
    `CHK(reset_indicator_out_n_n, 1'b0, "reset out on source")
    wait_reset_indicator_out_n();
    @(posedge clk_i);
    want_lock <= 0;
    repeat (5) @(posedge clk_i);
    `CHK(reset_indicator_out_n_n, 1'b0, "reset out on lock loss")
    want_lock <= 1;
    wait_reset_indicator_out_n();
    `CHK((n >= STR && n <= STR + 5), 1'b1, "stretch after lock")
    // test pin high at reset exit keeps programming mode off
    @(posedge clk_i);
    want_rst_n <= 0; want_mode <= 2'h0; want_strap <= 0; want_cfg_n <= 0;
    want_test <= 1;
    repeat (5) @(posedge clk_i);
    want_rst_n <= 1;
    wait_reset_indicator_out_n();
    check_boot(2'h0, 1'b0, 1'b1);
    @(posedge clk_i);
    want_test <= 0;
    @(negedge clk_i);
    `CHK(sclk, clk_i, "clock out low phase")
    print_verdict();
  end
endmodule
`undef CHK
`default_nettype wire
